// >>> dv/pct_pin_model.sv
// Purpose: trigger and reset pin source standing beside the unit
// Assumes: both pins are pulled up, so an idle pin reads high
// Notes: pins change only by non-blocking assignment after a rising edge
module pct_pin_model (
    input wire logic pclk, // System clock
    output logic external_trigger_n, // Trigger pin, active low
    output logic external_reset_n // Reset pin, active low
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-ups keep both pins high while nothing shorts them
    initial begin
        external_trigger_n = 1'b1;
        external_reset_n = 1'b1;
    end
    // Short one pin to ground; it stays low until released
    task automatic pin_low(input bit rst);
        @(posedge pclk);
        if (rst) begin
            external_reset_n <= 1'b0;
        end else begin
            external_trigger_n <= 1'b0;
        end
    endtask
    // Release goes back to the pulled-up level, never to a held value
    task automatic release_pins();
        @(posedge pclk);
        external_trigger_n <= 1'b1;
        external_reset_n <= 1'b1;
    endtask
endmodule

// >>> dv/pulse_control_line_trigger_unit_tb.sv
// Purpose: self-checking bench for the control line and trigger unit
// Assumes: 40 MHz pclk, zero-wait APB, pins driven by the pin model
// Notes: register reset values first, then flag table, triggers, pause, reset and scans
module pulse_control_line_trigger_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pct_pkg::*;
    // ***********************************************
    // Signals and instances
    // ***********************************************
    typedef struct {logic [23:0] fw; logic [18:0] exp; logic gate;} pct_row_type;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, capt_data, rd;
    logic flag_load, seq_pause, seq_halt, seq_start, seq_resume, seq_reset;
    logic external_trigger_n, external_reset_n, phase_zero, capt_valid, er;
    logic [FLAG_W-1:0] flag_word;
    logic [FREQ_W-1:0] freq_sel;
    logic [RXPH_W-1:0] cos_phase_sel, sin_phase_sel;
    logic [TXPH_W-1:0] tx_phase_sel;
    logic [USER_W-1:0] user_out;
    logic [13:0] tx_sample, analog_out;
    int err_total, checked, n;
    logic [31:0] pts [4] = '{32'h66, 32'h77, 32'h88, 32'h99};
    pct_row_type rows [4] = '{
        '{24'h000000, 19'h0, 1'b0},
        '{24'h6c1a45, {4'ha, 2'b10, 2'b01, 4'hc, 1'b1, 6'h05}, 1'b1},
        '{24'h93e03b, {4'h0, 2'b01, 2'b10, 4'h3, 1'b0, 6'h3b}, 1'b0},
        '{24'hff1f7f, {4'hf, 2'b11, 2'b11, 4'hf, 1'b1, 6'h3f}, 1'b1}};
    pct_unit uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .flag_load(flag_load),
        .flag_word(flag_word), .seq_pause(seq_pause), .seq_halt(seq_halt),
        .seq_start(seq_start), .seq_resume(seq_resume), .seq_reset(seq_reset),
        .external_trigger_n(external_trigger_n), .external_reset_n(external_reset_n),
        .freq_sel(freq_sel), .cos_phase_sel(cos_phase_sel),
        .sin_phase_sel(sin_phase_sel), .tx_phase_sel(tx_phase_sel),
        .phase_zero(phase_zero), .user_out(user_out), .tx_sample(tx_sample),
        .analog_out(analog_out), .capt_valid(capt_valid), .capt_data(capt_data));
    pct_pin_model pins (.pclk(pclk), .external_trigger_n(external_trigger_n),
        .external_reset_n(external_reset_n));
    // ***********************************************
    // Shared tasks
    // ***********************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic load(input logic [23:0] fw);
        @(posedge pclk);
        flag_load <= 1'b1;
        flag_word <= fw;
        @(posedge pclk);
        flag_load <= 1'b0;
    endtask
    // One-cycle strobe: 0 pause, 1 halt, 2 captured point
    task automatic pulse(input int k, input logic [31:0] d);
        @(posedge pclk);
        seq_pause <= (k == 0);
        seq_halt <= (k == 1);
        capt_valid <= (k == 2);
        capt_data <= d;
        @(posedge pclk);
        {seq_pause, seq_halt, capt_valid} <= 3'h0;
    endtask
    // Edges until a start (k 0) or resume (k 1) strobe, capped at lim
    task automatic await(input int k, input int lim, output int c);
        c = 0;
        do begin
            @(posedge pclk);
            c++;
        end while (((k == 0) ? seq_start : seq_resume) !== 1'b1 && c < lim);
    endtask
    task automatic results();
        if (err_total == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ***********************************************
    // Clock, watchdog and main sequence
    // ***********************************************
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Whole run is a few hundred cycles; this cap only catches a hang
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        results();
    end
    initial begin
        {presetn, psel, penable, pwrite, flag_load, seq_pause, seq_halt} = 7'h0;
        {paddr, pwdata, capt_data, capt_valid} = 73'h0;
        flag_word = 24'h0;
        tx_sample = 14'h2a5c;
        err_total = 0;
        checked = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rchk(STATUS_OFS, 32'h3);
        rchk(NPTS_OFS, 32'h2000);
        rchk(IRQ_MASK_OFS, 32'h0);
        apb(1'b1, STATUS_OFS, 32'hffffffff);
        rchk(STATUS_OFS, 32'h3);
        apb(1'b0, 8'h20, 32'h0);
        chk({er, rd}, {1'b1, 32'h0});
        // Flag rows; the word changes afterwards with no load strobe
        foreach (rows[i]) begin
            load(rows[i].fw);
            flag_word <= ~rows[i].fw;
            repeat (4) @(posedge pclk);
            chk({freq_sel, cos_phase_sel, sin_phase_sel, tx_phase_sel, phase_zero,
                user_out}, rows[i].exp);
            chk(analog_out, rows[i].gate ? tx_sample : 14'h0);
        end
        apb(1'b1, NPTS_OFS, 32'h4);
        apb(1'b1, IRQ_MASK_OFS, 32'h7);
        pins.pin_low(1'b0);
        await(0, 20, n);
        pins.release_pins();
        chk(n <= 6, 1);
        rchk(STATUS_OFS, 32'h6);
        apb(1'b1, CTRL_OFS, 32'h1);
        await(0, 10, n);
        chk(n, 10);
        // Pause, then resume once by software and once by the pin
        for (int k = 0; k < 2; k++) begin
            pulse(0, 32'h0);
            rchk(STATUS_OFS, 32'ha);
            chk(irq, 1);
            rchk(IRQ_STAT_OFS, 32'h2);
            @(posedge pclk);
            chk(irq, 0);
            if (k == 0) begin
                apb(1'b1, CTRL_OFS, 32'h1);
            end else begin
                pins.pin_low(1'b0);
            end
            await(1, 30, n);
            pins.release_pins();
            chk(seq_resume, 0);
            chk(n >= 8 && n <= 14, 1);
            rchk(STATUS_OFS, 32'h6);
        end
        pulse(1, 32'h0);
        rchk(STATUS_OFS, 32'h3);
        rchk(IRQ_STAT_OFS, 32'h4);
        pins.pin_low(1'b1);
        repeat (5) @(posedge pclk);
        chk(seq_reset, 1);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk(rd[1], 0);
        pins.release_pins();
        repeat (3) @(posedge pclk);
        pins.pin_low(1'b0);
        await(0, 20, n);
        pins.release_pins();
        chk(n <= 6, 1);
        // Software program reset, then a software restart
        apb(1'b1, CTRL_OFS, 32'h2);
        rchk(STATUS_OFS, 32'h0);
        chk(seq_reset, 1);
        apb(1'b1, CTRL_OFS, 32'h1);
        await(0, 10, n);
        chk(n <= 2, 1);
        // Scan: line held high across two loads starts only one scan
        apb(1'b1, IRQ_MASK_OFS, 32'h6);
        load(24'h80);
        rchk(STATUS_OFS, 32'h16);
        pulse(2, 32'h11);
        pulse(2, 32'h22);
        load(24'h80);
        pulse(2, 32'h33);
        pulse(2, 32'h44);
        pulse(2, 32'h55);
        rchk(CAPT_CNT_OFS, 32'h4);
        chk(irq, 0);
        rchk(IRQ_STAT_OFS, 32'h1);
        rchk(STATUS_OFS, 32'h6);
        // New scan survives its line dropping; readout runs mid-scan
        load(24'h0);
        load(24'h80);
        pulse(2, pts[0]);
        load(24'h0);
        apb(1'b1, RD_ADDR_OFS, 32'h0);
        rchk(RD_DATA_OFS, pts[0]);
        for (int i = 1; i < 4; i++) begin
            pulse(2, pts[i]);
        end
        rchk(CAPT_CNT_OFS, 32'h4);
        for (int i = 1; i < 4; i++) begin
            rchk(RD_DATA_OFS, pts[i]);
        end
        results();
    end
endmodule

// >>> logic/pct_mem.sv
// Purpose: dual-port sample store with registered read data
// Assumes: one write port for capture, one read port for host
// Notes: reads and writes run independently
module pct_mem
    import pct_pkg::*;
#(
    parameter int DW = 32,
    parameter int AW = 8
) (
    input wire logic pclk, // System clock
    input wire logic wr_en, // Write strobe
    input wire logic [AW-1:0] wr_addr, // Write address
    input wire logic [DW-1:0] wr_data, // Write data
    input wire logic [AW-1:0] rd_addr, // Read address
    output logic [DW-1:0] rd_data // Registered read data
);
    logic [DW-1:0] mem [2**AW];

    // No reset on the array; read port is free-running
    always_ff @(posedge pclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// >>> logic/pct_pkg.sv
// Purpose: constants for the pulse control line and trigger unit
// Assumes: 40 MHz pclk, 32-bit APB register bus
// Notes: flag word layout, register map, run-state codes
//
// Function
// - Hold decoded flag lines for whole instruction
// - Frequency field selects active frequency register
// - Separate cos, sin, TX phase select fields
// - TX gate passes or zeroes analog output
// - Phase-zero line holds synthesizer channels at zero
// - Scan starts only on rising scan line
// - Scan runs until configured point count captured
// - Software trigger acts like hardware trigger
// - Idle external trigger starts within three cycles
// - Paused trigger resumes no sooner than eight cycles
// - Trigger starts, restarts, or resumes program
// - Triggers never start acquisition directly
// - Five-bit status, reset flag active low
// - Samples readable any time, even mid-scan
// - Pause waits trigger, resumes after fixed latency
// - Low external reset resets the pulse program
package pct_pkg;
    // ***********************************************
    // Flag word layout
    // ***********************************************
    localparam int FLAG_W = 24;
    localparam int USER_LSB = 0;
    localparam int USER_W = 6;
    localparam int PHZ_BIT = 6;
    localparam int SCAN_BIT = 7;
    localparam int FREQ_LSB = 8;
    localparam int FREQ_W = 4;
    localparam int TXEN_BIT = 12;
    localparam int TXPH_LSB = 16;
    localparam int TXPH_W = 4;
    localparam int COSPH_LSB = 20;
    localparam int SINPH_LSB = 22;
    localparam int RXPH_W = 2;
    // ***********************************************
    // Register map (byte addresses)
    // ***********************************************
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] NPTS_OFS = 8'h08;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h0c;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h10;
    localparam logic [7:0] RD_ADDR_OFS = 8'h14;
    localparam logic [7:0] RD_DATA_OFS = 8'h18;
    localparam logic [7:0] CAPT_CNT_OFS = 8'h1c;
    localparam int CTRL_TRIG_BIT = 0;
    localparam int CTRL_RST_BIT = 1;
    localparam int ST_STOP_BIT = 0;
    localparam int ST_RSTN_BIT = 1;
    localparam int ST_RUN_BIT = 2;
    localparam int ST_WAIT_BIT = 3;
    localparam int ST_SCAN_BIT = 4;
    localparam int IRQ_SCAN_BIT = 0;
    localparam int IRQ_PAUSE_BIT = 1;
    localparam int IRQ_HALT_BIT = 2;
    localparam int IRQ_W = 3;
    localparam logic [15:0] NPTS_RESET = 16'h2000;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
    // ***********************************************
    // Timing
    // ***********************************************
    localparam int CLK_MHZ = 40;
    localparam int RESUME_MIN_CYC = 8;
    localparam int PAUSE_FIXED_CYC = 6;
    localparam int RESUME_CYC = (RESUME_MIN_CYC > PAUSE_FIXED_CYC) ?
                                RESUME_MIN_CYC : PAUSE_FIXED_CYC;
    // Run state of the pulse program
    typedef enum logic [1:0] {
        RS_STOPPED = 2'b00,
        RS_RUNNING = 2'b01,
        RS_WAITING = 2'b10,
        RS_RESET = 2'b11
    } pct_run_type;
endpackage

// >>> logic/pct_sync.sv
// Purpose: two-stage synchroniser for asynchronous pin inputs
// Assumes: inputs idle high (pulled up), resets to one
// Notes: only the second stage may be read by logic
module pct_sync
    import pct_pkg::*;
#(
    parameter int W = 2
) (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic [W-1:0] din, // Asynchronous inputs
    output logic [W-1:0] dout // Synchronised outputs
);
    logic [W-1:0] meta;

    // Two flops; first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= '1;
            dout <= '1;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// >>> logic/pct_unit.sv
// Purpose: flag-word decode, trigger handling, scan control, APB regs
// Assumes: sequencer pulses flag_load at each instruction start
// Notes: read of irq status clears it; pready is always high
//
// Design decisions made here: register access over APB and the register addresses.
module pct_unit
    import pct_pkg::*;
#(
    parameter int SAMPLE_W = 14,
    parameter int MEM_AW = 8
) (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    output logic irq, // Level interrupt
    input wire logic flag_load, // New instruction starts
    input wire logic [FLAG_W-1:0] flag_word, // Flags of that instruction
    input wire logic seq_pause, // Pause instruction executed
    input wire logic seq_halt, // Stop instruction executed
    output logic seq_start, // Start or restart program pulse
    output logic seq_resume, // Resume from pause pulse
    output logic seq_reset, // Program reset level
    input wire logic external_trigger_n, // Trigger pin, active low
    input wire logic external_reset_n, // Reset pin, active low
    output logic [FREQ_W-1:0] freq_sel, // Frequency register select
    output logic [RXPH_W-1:0] cos_phase_sel, // Receiver cos phase select
    output logic [RXPH_W-1:0] sin_phase_sel, // Receiver sin phase select
    output logic [TXPH_W-1:0] tx_phase_sel, // TX phase select
    output logic phase_zero, // Hold synthesizers at zero phase
    output logic [USER_W-1:0] user_out, // User digital outputs
    input wire logic [SAMPLE_W-1:0] tx_sample, // TX synthesizer sample
    output logic [SAMPLE_W-1:0] analog_out, // Gated TX sample
    input wire logic capt_valid, // Baseband point available
    input wire logic [31:0] capt_data // Complex point data
);
    // ***********************************************
    // Flag word hold
    // ***********************************************
    logic [FLAG_W-1:0] flags;

    // Captured once per instruction, stable through its delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= '0;
        end else if (flag_load) begin
            flags <= flag_word;
        end
    end

    assign freq_sel = flags[FREQ_LSB +: FREQ_W];
    assign cos_phase_sel = flags[COSPH_LSB +: RXPH_W];
    assign sin_phase_sel = flags[SINPH_LSB +: RXPH_W];
    assign tx_phase_sel = flags[TXPH_LSB +: TXPH_W];
    assign phase_zero = flags[PHZ_BIT];
    assign user_out = flags[USER_LSB +: USER_W];
    wire tx_gate = flags[TXEN_BIT];
    wire scan_line = flags[SCAN_BIT];

    // Gated output register; zero rather than idle sample when closed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_out <= '0;
        end else begin
            analog_out <= tx_gate ? tx_sample : '0;
        end
    end

    // ***********************************************
    // APB decode
    // ***********************************************
    wire apb_acc = psel && penable;
    wire apb_wr = apb_acc && pwrite;
    wire apb_rd = apb_acc && !pwrite;
    wire hit_ctrl = (paddr == CTRL_OFS);
    wire hit_stat = (paddr == STATUS_OFS);
    wire hit_npts = (paddr == NPTS_OFS);
    wire hit_istat = (paddr == IRQ_STAT_OFS);
    wire hit_imask = (paddr == IRQ_MASK_OFS);
    wire hit_raddr = (paddr == RD_ADDR_OFS);
    wire hit_rdata = (paddr == RD_DATA_OFS);
    wire hit_ccnt = (paddr == CAPT_CNT_OFS);
    wire hit_any = hit_ctrl | hit_stat | hit_npts | hit_istat | hit_imask |
                   hit_raddr | hit_rdata | hit_ccnt;
    assign pready = 1'b1;
    assign pslverr = apb_acc && !hit_any;
    wire sw_trig = apb_wr && hit_ctrl && pwdata[CTRL_TRIG_BIT];
    wire sw_rst = apb_wr && hit_ctrl && pwdata[CTRL_RST_BIT];

    // ***********************************************
    // Pin synchronisation and trigger detect
    // ***********************************************
    logic [1:0] pins_s;
    logic trig_s_d;

    pct_sync #(.W(2)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din({external_reset_n, external_trigger_n}),
        .dout(pins_s)
    );

    wire trig_s = pins_s[0];
    wire ext_rst_s = !pins_s[1];

    // Edge history on the synchronised copy only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_s_d <= 1'b1;
        end else begin
            trig_s_d <= trig_s;
        end
    end

    wire hw_trig = trig_s_d && !trig_s;
    // Software trigger merges into the same path, timing not precise
    wire any_trig = hw_trig || sw_trig;

    // ***********************************************
    // Run state machine
    // ***********************************************
    pct_run_type run_state, next_run_state;
    logic [3:0] resume_cnt;
    logic resume_pend;

    // Trigger meaning depends on state; triggers never touch the scan
    always_comb begin
        next_run_state = run_state;
        case (run_state)
            RS_STOPPED: if (any_trig) next_run_state = RS_RUNNING;
            RS_RESET: if (any_trig) next_run_state = RS_RUNNING;
            RS_RUNNING: begin
                if (seq_halt) begin
                    next_run_state = RS_STOPPED;
                end else if (seq_pause) begin
                    next_run_state = RS_WAITING;
                end
            end
            RS_WAITING: if (seq_resume) next_run_state = RS_RUNNING;
            default: next_run_state = RS_STOPPED;
        endcase
        if (ext_rst_s || sw_rst) begin
            next_run_state = RS_RESET;
        end
    end

    wire start_now = any_trig && !ext_rst_s && !sw_rst &&
                     ((run_state == RS_STOPPED) || (run_state == RS_RESET));

    // Start pulse one cycle after the detected edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_state <= RS_STOPPED;
            seq_start <= 1'b0;
        end else begin
            run_state <= next_run_state;
            seq_start <= start_now;
        end
    end

    assign seq_reset = (run_state == RS_RESET);

    // Resume delayed by a fixed count; reset cancels a pending resume
    wire arm_resume = any_trig && (run_state == RS_WAITING) && !resume_pend;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resume_cnt <= '0;
            resume_pend <= 1'b0;
        end else if (run_state != RS_WAITING) begin
            resume_cnt <= '0;
            resume_pend <= 1'b0;
        end else if (arm_resume) begin
            resume_cnt <= 4'(RESUME_CYC - 1);
            resume_pend <= 1'b1;
        end else if (resume_pend && resume_cnt != '0) begin
            resume_cnt <= resume_cnt - 4'h1;
        end
    end

    // State gate keeps the pulse to one cycle while the pending flag clears
    assign seq_resume = resume_pend && (resume_cnt == '0) && (run_state == RS_WAITING) &&
                        !ext_rst_s && !sw_rst;

    // ***********************************************
    // Scan control and capture
    // ***********************************************
    logic scan_line_d, scanning;
    logic [15:0] npts, capt_cnt;
    logic [MEM_AW-1:0] rd_ptr;
    logic [31:0] mem_rdata;

    // Edge memory of the scan line; a held level never re-arms
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_line_d <= 1'b0;
        end else begin
            scan_line_d <= scan_line;
        end
    end

    // Only the program's flag line starts a scan, never a trigger
    wire scan_rise = scan_line && !scan_line_d;
    wire capt_wr = scanning && capt_valid;
    wire scan_last = capt_wr && (capt_cnt == npts - 16'h1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scanning <= 1'b0;
            capt_cnt <= '0;
        end else if (!scanning) begin
            if (scan_rise && npts != '0) begin
                scanning <= 1'b1;
                capt_cnt <= '0;
            end
        end else if (capt_wr) begin
            capt_cnt <= capt_cnt + 16'h1;
            if (scan_last) begin
                scanning <= 1'b0;
            end
        end
    end

    pct_mem #(.DW(32), .AW(MEM_AW)) u_mem (
        .pclk(pclk),
        .wr_en(capt_wr),
        .wr_addr(capt_cnt[MEM_AW-1:0]),
        .wr_data(capt_data),
        .rd_addr(rd_ptr),
        .rd_data(mem_rdata)
    );

    // Host pointer independent of capture; auto-advance on data reads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ptr <= '0;
        end else if (apb_wr && hit_raddr) begin
            rd_ptr <= pwdata[MEM_AW-1:0];
        end else if (apb_rd && hit_rdata) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end

    // ***********************************************
    // Status, interrupts and read mux
    // ***********************************************
    logic [IRQ_W-1:0] irq_stat, irq_mask;
    wire [4:0] run_status = {scanning, run_state == RS_WAITING, run_state == RS_RUNNING,
                             run_state != RS_RESET, run_state == RS_STOPPED};
    wire [IRQ_W-1:0] irq_evt = {seq_halt && run_state == RS_RUNNING,
                                seq_pause && run_state == RS_RUNNING, scan_last};
    wire irq_clr = apb_rd && hit_istat;

    // New events win over the read that clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= '0;
            irq_mask <= IRQ_MASK_RESET;
            npts <= NPTS_RESET;
        end else begin
            irq_stat <= (irq_clr ? '0 : irq_stat) | irq_evt;
            if (apb_wr && hit_imask) irq_mask <= pwdata[IRQ_W-1:0];
            if (apb_wr && hit_npts) npts <= pwdata[15:0];
        end
    end

    assign irq = |(irq_stat & irq_mask);
    assign prdata = hit_stat ? {27'h0, run_status} :
                    hit_npts ? {16'h0, npts} :
                    hit_istat ? {29'h0, irq_stat} :
                    hit_imask ? {29'h0, irq_mask} :
                    hit_raddr ? {{(32-MEM_AW){1'b0}}, rd_ptr} :
                    hit_rdata ? mem_rdata :
                    hit_ccnt ? {16'h0, capt_cnt} : 32'h0;

    // ***********************************************
    // Checks
    // ***********************************************
    a_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(flag_load) |-> $stable(freq_sel) && $stable(tx_phase_sel))
        else $error("flag lines changed without a new instruction");
    a_tx_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(tx_gate) |-> analog_out == '0)
        else $error("analog output not zero while gate closed");
    a_scan_edge: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(scanning) |-> $past(scan_rise))
        else $error("scan started without rising scan line");
    a_scan_runs: assert property (@(posedge pclk) disable iff (!presetn)
        scanning && !scan_last |=> scanning)
        else $error("scan ended before point count reached");
    a_idle_start: assert property (@(posedge pclk) disable iff (!presetn)
        hw_trig && run_state == RS_STOPPED && !ext_rst_s && !sw_rst |-> ##1 seq_start)
        else $error("idle trigger did not start program");
    a_resume_late: assert property (@(posedge pclk) disable iff (!presetn)
        arm_resume |-> !seq_resume [*8])
        else $error("resume came too early after trigger");
    a_resume_due: assert property (@(posedge pclk) disable iff (!presetn)
        arm_resume && !ext_rst_s ##1 (run_state == RS_WAITING && !ext_rst_s && !sw_rst) [*8]
        |-> seq_resume)
        else $error("resume not issued after fixed latency");
    a_resume_once: assert property (@(posedge pclk) disable iff (!presetn)
        seq_resume |=> !seq_resume)
        else $error("resume pulse longer than one cycle");
    a_reset_flag: assert property (@(posedge pclk) disable iff (!presetn)
        ext_rst_s |=> !run_status[ST_RSTN_BIT] && seq_reset)
        else $error("external reset did not reset program");
    a_irq_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        irq_evt[IRQ_SCAN_BIT] |=> irq_stat[IRQ_SCAN_BIT])
        else $error("scan done event lost");
endmodule
